/* common/timer_wave_pkg.sv */
package timer_wave_pkg;
    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] OFS_CTRL_A = 8'h30;
    localparam logic [7:0] OFS_CTRL_B = 8'h34;
    localparam logic [7:0] OFS_CMP_A = 8'h38;
    localparam logic [7:0] OFS_CMP_B = 8'h3c;
    localparam logic [7:0] OFS_COUNT = 8'h40;
    localparam logic [7:0] OFS_STATUS = 8'h44;
    localparam logic [7:0] CTRL_A_RESET = 8'h00;
    localparam logic [7:0] CTRL_A_WMASK = 8'hf3;
    localparam int ACT_A_HI = 7;
    localparam int ACT_A_LO = 6;
    localparam int ACT_B_HI = 5;
    localparam int ACT_B_LO = 4;
    localparam int MODE_MID = 1;
    localparam int MODE_LO = 0;
    localparam int CTRLB_MODE_HI = 3;
    localparam int CTRLB_RUN = 0;
    localparam int ST_OVF = 0;
    localparam int ST_MATCH_A = 1;
    localparam int ST_MATCH_B = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] ACT_OFF = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;

    typedef enum logic [4:0] {
        WC_NORMAL = 5'h01,
        WC_CTC = 5'h02,
        WC_PC = 5'h04,
        WC_FAST = 5'h08,
        WC_RSV = 5'h10
    } wave_class_t;

    function automatic wave_class_t decode_class(input logic [2:0] mode);
        case (mode)
            3'h0: decode_class = WC_NORMAL;
            3'h1, 3'h5: decode_class = WC_PC;
            3'h2: decode_class = WC_CTC;
            3'h3, 3'h7: decode_class = WC_FAST;
            default: decode_class = WC_RSV;
        endcase
    endfunction : decode_class

    function automatic logic top_from_a(input logic [2:0] mode);
        top_from_a = (mode == 3'h2) || (mode == 3'h5) || (mode == 3'h7);
    endfunction : top_from_a

    function automatic logic ovf_at_max(input logic [2:0] mode);
        ovf_at_max = (mode == 3'h0) || (mode == 3'h2) || (mode == 3'h3);
    endfunction : ovf_at_max
endpackage : timer_wave_pkg

/* hdl/timer_count_unit.sv */
module timer_count_unit (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic tick,
    input wire timer_wave_pkg::wave_class_t wclass,
    input wire logic [7:0] top,
    input wire logic load,
    input wire logic [7:0] load_value,
    output logic [7:0] count,
    output logic count_down,
    output logic wrap_tick,
    output logic top_tick
);
    import timer_wave_pkg::*;

    logic [7:0] count_ff;
    logic [7:0] nxt_count;
    logic down_ff;
    logic nxt_down;
    logic at_top;
    logic at_bottom;

    assign at_top = count_ff == top;
    assign at_bottom = count_ff == CNT_BOTTOM;
    assign count = count_ff;
    assign count_down = down_ff;
    assign top_tick = tick && at_top && !down_ff;
    assign wrap_tick = tick && (((wclass == WC_CTC || wclass == WC_FAST)
        && at_top) || ((wclass == WC_NORMAL || wclass == WC_RSV)
        && count_ff == CNT_MAX));

    always_comb begin
        nxt_count = count_ff + 8'h01;
        nxt_down = 1'b0;
        case (wclass)
            WC_PC: begin
                nxt_down = down_ff;
                if (!down_ff && at_top && !at_bottom) begin
                    nxt_down = 1'b1;
                    nxt_count = count_ff - 8'h01;
                end else if (!down_ff && at_top) begin
                    nxt_count = count_ff;
                end else if (down_ff && at_bottom) begin
                    nxt_down = 1'b0;
                end else if (down_ff) begin
                    nxt_count = count_ff - 8'h01;
                end
            end
            WC_CTC, WC_FAST: begin
                if (at_top) begin
                    nxt_count = CNT_BOTTOM;
                end
            end
            default: begin
                // reserved modes run like normal mode
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_ff <= CNT_BOTTOM;
            down_ff <= 1'b0;
        end else if (ce && load) begin
            count_ff <= load_value;
        end else if (ce && tick) begin
            count_ff <= nxt_count;
            down_ff <= nxt_down;
        end
    end

    a_pc_turn_down: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && !load && tick && wclass == WC_PC && !down_ff && at_top
        && top != CNT_BOTTOM |=> down_ff && count_ff == $past(top) - 8'h01)
        else $error("phase-correct count did not turn at top");
endmodule : timer_count_unit

/* hdl/compare_out_unit.sv */
module compare_out_unit #(
    parameter bit TOGGLE_OK = 1'b1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic tick,
    input wire timer_wave_pkg::wave_class_t wclass,
    input wire logic mode_hi,
    input wire logic [1:0] action,
    input wire logic [7:0] cmp,
    input wire logic [7:0] count,
    input wire logic count_down,
    input wire logic wrap_tick,
    output logic out
);
    import timer_wave_pkg::*;

    logic out_ff;
    logic nxt_out;
    logic match;
    logic bottom_level;
    logic up_level;

    assign match = tick && count == cmp;
    assign out = out_ff;
    assign bottom_level = action == ACT_CLEAR;
    assign up_level = action == ACT_SET;

    always_comb begin
        nxt_out = out_ff;
        case (wclass)
            WC_NORMAL, WC_CTC: begin
                if (match) begin
                    case (action)
                        ACT_TOGGLE: nxt_out = !out_ff;
                        ACT_CLEAR: nxt_out = 1'b0;
                        ACT_SET: nxt_out = 1'b1;
                        default: nxt_out = out_ff;
                    endcase
                end
            end
            WC_FAST, WC_PC: begin
                if (action[1] && wclass == WC_FAST) begin
                    // wrap wins: a match at TOP is dropped
                    if (wrap_tick) begin
                        nxt_out = bottom_level;
                    end else if (match) begin
                        nxt_out = !bottom_level;
                    end
                end else if (action[1]) begin
                    // at TOP direction is still up, so TOP acts as up-match
                    if (match) begin
                        nxt_out = count_down ? !up_level : up_level;
                    end
                end else if (TOGGLE_OK && mode_hi && match &&
                        action == ACT_TOGGLE) begin
                    nxt_out = !out_ff;
                end
            end
            default: begin
                // reserved modes: compare actions suppressed
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_ff <= 1'b0;
        end else if (ce) begin
            out_ff <= nxt_out;
        end
    end

    a_fast_bottom: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && wclass == WC_FAST && wrap_tick && action == ACT_CLEAR
        |=> out_ff)
        else $error("fast pwm non-inverting did not set at bottom");

    a_plain_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && (wclass == WC_NORMAL || wclass == WC_CTC) && match
        && action == ACT_TOGGLE |=> out_ff != $past(out_ff))
        else $error("non-pwm toggle missing");

    a_pc_direction: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && wclass == WC_PC && match && action == ACT_CLEAR
        |=> out_ff == $past(count_down))
        else $error("phase-correct level wrong for direction");

    a_reserved_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        wclass == WC_RSV |=> $stable(out_ff))
        else $error("output moved in reserved mode");

    a_no_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
        (!TOGGLE_OK || !mode_hi) && (wclass == WC_FAST || wclass == WC_PC)
        && action == ACT_TOGGLE |=> $stable(out_ff))
        else $error("toggle where none is allowed");
endmodule : compare_out_unit

/* hdl/timer_wave_ctrl.sv */
module timer_wave_ctrl (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic port_a_data,
    input wire logic port_a_dir,
    input wire logic port_b_data,
    input wire logic port_b_dir,
    output logic pin_a_o,
    output logic pin_a_oe,
    output logic pin_b_o,
    output logic pin_b_oe
);
    import timer_wave_pkg::*;

    logic [7:0] ctrl_a_ff;
    logic mode_hi_ff;
    logic run_ff;
    logic [7:0] cmp_a_reg_ff;
    logic [7:0] cmp_b_reg_ff;
    logic [7:0] cmp_a_ff;
    logic [7:0] cmp_b_ff;
    logic ovf_flag_ff;
    logic match_a_flag_ff;
    logic match_b_flag_ff;
    logic aw_got_ff;
    logic w_got_ff;
    logic [7:0] awaddr_ff;
    logic [7:0] wdata_ff;
    logic wstrb0_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic [7:0] last_araddr_ff;
    logic pin_a_o_ff;
    logic pin_a_oe_ff;
    logic pin_b_o_ff;
    logic pin_b_oe_ff;

    logic [2:0] wave_mode;
    wave_class_t wclass;
    logic tick;
    logic [7:0] top;
    logic [7:0] count;
    logic count_down;
    logic wrap_tick;
    logic top_tick;
    logic out_a;
    logic out_b;
    logic route_a;
    logic route_b;
    logic ovf_ev;
    logic wr_en;
    logic [7:0] rd_mux;
    logic rd_mapped;
    logic [1:0] act_a;
    logic [1:0] act_b;

    function automatic logic wr_hit(input logic en, input logic [7:0] a,
            input logic [7:0] ofs);
        wr_hit = en && a == ofs;
    endfunction : wr_hit

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = a == OFS_CTRL_A || a == OFS_CTRL_B || a == OFS_CMP_A
            || a == OFS_CMP_B || a == OFS_COUNT || a == OFS_STATUS;
    endfunction : is_mapped

    assign act_a = ctrl_a_ff[ACT_A_HI:ACT_A_LO];
    assign act_b = ctrl_a_ff[ACT_B_HI:ACT_B_LO];
    assign wave_mode = {mode_hi_ff, ctrl_a_ff[MODE_MID:MODE_LO]};
    assign wclass = decode_class(wave_mode);
    assign tick = ce && run_ff;
    assign top = top_from_a(wave_mode) ? cmp_a_ff : CNT_MAX;
    assign route_a = act_a != ACT_OFF
        && !(act_a == ACT_TOGGLE && !mode_hi_ff
        && (wclass == WC_FAST || wclass == WC_PC));
    assign route_b = act_b != ACT_OFF;

    // bus: one write and one read in flight; a read is answered one cycle on, a write two cycles on
    assign awready = ce && !aw_got_ff && !bvalid_ff;
    assign wready = ce && !w_got_ff && !bvalid_ff;
    assign arready = ce && !rvalid_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;
    assign wr_en = ce && aw_got_ff && w_got_ff && !bvalid_ff && wstrb0_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 8'h00;
            wstrb0_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (ce) begin
            if (awvalid && awready) begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= awaddr;
            end
            if (wvalid && wready) begin
                w_got_ff <= 1'b1;
                wdata_ff <= wdata[7:0];
                wstrb0_ff <= wstrb[0];
            end
            if (aw_got_ff && w_got_ff && !bvalid_ff) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= is_mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_ff && bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_comb begin
        rd_mux = 8'h00;
        rd_mapped = 1'b1;
        case (araddr)
            OFS_CTRL_A: rd_mux = ctrl_a_ff & CTRL_A_WMASK;
            OFS_CTRL_B: begin
                rd_mux[CTRLB_MODE_HI] = mode_hi_ff;
                rd_mux[CTRLB_RUN] = run_ff;
            end
            OFS_CMP_A: rd_mux = cmp_a_reg_ff;
            OFS_CMP_B: rd_mux = cmp_b_reg_ff;
            OFS_COUNT: rd_mux = count;
            OFS_STATUS: begin
                rd_mux[ST_OVF] = ovf_flag_ff;
                rd_mux[ST_MATCH_A] = match_a_flag_ff;
                rd_mux[ST_MATCH_B] = match_b_flag_ff;
            end
            default: rd_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= RESP_OKAY;
            last_araddr_ff <= 8'h00;
        end else if (ce) begin
            if (arvalid && arready) begin
                rvalid_ff <= 1'b1;
                rdata_ff <= {24'h000000, rd_mux};
                rresp_ff <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
                last_araddr_ff <= araddr;
            end else if (rvalid_ff && rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_a_ff <= CTRL_A_RESET;
            mode_hi_ff <= 1'b0;
            run_ff <= 1'b0;
            cmp_a_reg_ff <= CNT_BOTTOM;
            cmp_b_reg_ff <= CNT_BOTTOM;
        end else begin
            if (wr_hit(wr_en, awaddr_ff, OFS_CTRL_A)) begin
                ctrl_a_ff <= wdata_ff & CTRL_A_WMASK;
            end
            if (wr_hit(wr_en, awaddr_ff, OFS_CTRL_B)) begin
                mode_hi_ff <= wdata_ff[CTRLB_MODE_HI];
                run_ff <= wdata_ff[CTRLB_RUN];
            end
            if (wr_hit(wr_en, awaddr_ff, OFS_CMP_A)) begin
                cmp_a_reg_ff <= wdata_ff;
            end
            if (wr_hit(wr_en, awaddr_ff, OFS_CMP_B)) begin
                cmp_b_reg_ff <= wdata_ff;
            end
        end
    end

    // active compare values: double buffered in the pwm modes so a
    // write mid-period cannot cut a pulse short
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmp_a_ff <= CNT_BOTTOM;
            cmp_b_ff <= CNT_BOTTOM;
        end else if (ce) begin
            case (wclass)
                WC_PC: begin
                    if (top_tick) begin
                        cmp_a_ff <= cmp_a_reg_ff;
                        cmp_b_ff <= cmp_b_reg_ff;
                    end
                end
                WC_FAST: begin
                    if (wrap_tick) begin
                        cmp_a_ff <= cmp_a_reg_ff;
                        cmp_b_ff <= cmp_b_reg_ff;
                    end
                end
                default: begin
                    cmp_a_ff <= cmp_a_reg_ff;
                    cmp_b_ff <= cmp_b_reg_ff;
                end
            endcase
        end
    end

    // overflow point depends on mode
    assign ovf_ev = tick && ((ovf_at_max(wave_mode) && count == CNT_MAX)
        || (wclass == WC_PC && count_down && count == CNT_BOTTOM)
        || (wave_mode == 3'h7 && count == top));

    // status flags: write one to clear, a new event in the same cycle wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ovf_flag_ff <= 1'b0;
            match_a_flag_ff <= 1'b0;
            match_b_flag_ff <= 1'b0;
        end else if (ce) begin
            ovf_flag_ff <= ovf_ev || (ovf_flag_ff && !(wr_hit(wr_en,
                awaddr_ff, OFS_STATUS) && wdata_ff[ST_OVF]));
            match_a_flag_ff <= (tick && count == cmp_a_ff)
                || (match_a_flag_ff && !(wr_hit(wr_en, awaddr_ff,
                OFS_STATUS) && wdata_ff[ST_MATCH_A]));
            match_b_flag_ff <= (tick && count == cmp_b_ff)
                || (match_b_flag_ff && !(wr_hit(wr_en, awaddr_ff,
                OFS_STATUS) && wdata_ff[ST_MATCH_B]));
        end
    end

    timer_count_unit u_count (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .tick(tick),
        .wclass(wclass),
        .top(top),
        .load(wr_hit(wr_en, awaddr_ff, OFS_COUNT)),
        .load_value(wdata_ff),
        .count(count),
        .count_down(count_down),
        .wrap_tick(wrap_tick),
        .top_tick(top_tick)
    );

    compare_out_unit #(.TOGGLE_OK(1'b1)) u_out_a (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .tick(tick),
        .wclass(wclass),
        .mode_hi(mode_hi_ff),
        .action(act_a),
        .cmp(cmp_a_ff),
        .count(count),
        .count_down(count_down),
        .wrap_tick(wrap_tick),
        .out(out_a)
    );

    // channel b has no toggle in the pwm modes
    compare_out_unit #(.TOGGLE_OK(1'b0)) u_out_b (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .tick(tick),
        .wclass(wclass),
        .mode_hi(mode_hi_ff),
        .action(act_b),
        .cmp(cmp_b_ff),
        .count(count),
        .count_down(count_down),
        .wrap_tick(wrap_tick),
        .out(out_b)
    );

    // pin mux; the driver stays off until the direction bit asks for it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_a_o_ff <= 1'b0;
            pin_a_oe_ff <= 1'b0;
            pin_b_o_ff <= 1'b0;
            pin_b_oe_ff <= 1'b0;
        end else if (ce) begin
            pin_a_o_ff <= route_a ? out_a : port_a_data;
            pin_b_o_ff <= route_b ? out_b : port_b_data;
            pin_a_oe_ff <= port_a_dir;
            pin_b_oe_ff <= port_b_dir;
        end
    end

    assign pin_a_o = pin_a_o_ff;
    assign pin_a_oe = pin_a_oe_ff;
    assign pin_b_o = pin_b_o_ff;
    assign pin_b_oe = pin_b_oe_ff;

    a_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && route_a |=> pin_a_o_ff == $past(out_a))
        else $error("channel a compare output not on pin");

    a_route_b: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && !route_b |=> pin_b_o_ff == $past(port_b_data))
        else $error("channel b pin not on port data");

    a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        rvalid_ff && last_araddr_ff == OFS_CTRL_A |-> rdata_ff[3:2] == 2'h0)
        else $error("reserved control bits read nonzero");

    a_top_select: assert property (@(posedge aclk) disable iff (!aresetn)
        (wave_mode == 3'h5 || wave_mode == 3'h2) |-> top == cmp_a_ff)
        else $error("top not taken from compare a");

    a_ovf_at_max: assert property (@(posedge aclk) disable iff (!aresetn)
        tick && ovf_at_max(wave_mode) && count == CNT_MAX |=> ovf_flag_ff)
        else $error("overflow flag not set at max");

    a_buf_fast: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && wclass == WC_FAST && !wrap_tick |=> $stable(cmp_a_ff))
        else $error("fast pwm compare changed away from bottom");

    a_mode_class: assert property (@(posedge aclk) disable iff (!aresetn)
        mode_hi_ff && ctrl_a_ff[1:0] == 2'h1 |-> wclass == WC_PC)
        else $error("mode 5 not phase-correct");
endmodule : timer_wave_ctrl

/* verif/pin_model.sv */
module pin_model (
    input wire logic o,
    input wire logic oe,
    output logic level
);
    timeunit 1ns;
    timeprecision 1ns;
    // pull-up holds the pin high while the driver is off
    assign level = oe ? o : 1'b1;
endmodule : pin_model

/* verif/testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import timer_wave_pkg::*;
    logic aclk = 0, aresetn = 0, ce = 1;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [3:0] wstrb = 0;
    logic [1:0] bresp, rresp;
    logic pa_d = 0, pa_dir = 0, pb_d = 0, pb_dir = 0;
    logic pa_o, pa_oe, pb_o, pb_oe, lvl_a, lvl_b;
    int fails = 0, checked = 0;
    always #25 aclk = ~aclk;
    timer_wave_ctrl uut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .port_a_data(pa_d), .port_a_dir(pa_dir), .port_b_data(pb_d),
        .port_b_dir(pb_dir), .pin_a_o(pa_o), .pin_a_oe(pa_oe),
        .pin_b_o(pb_o), .pin_b_oe(pb_oe));
    pin_model model_a (.o(pa_o), .oe(pa_oe), .level(lvl_a));
    pin_model model_b (.o(pb_o), .oe(pb_oe), .level(lvl_b));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done;
        $display("fails %0d checked %0d", fails, checked);
        if (fails == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done
    // handshake judged at negedge, which shows what the next rise samples
    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       output logic [1:0] r);
        logic ta, tw, bd;
        bd = 0;
        @(posedge aclk);
        awvalid <= 1; awaddr <= a; wvalid <= 1; wdata <= d;
        wstrb <= 4'hf; bready <= 1;
        while (!bd) begin
            @(negedge aclk);
            ta = awvalid && awready; tw = wvalid && wready;
            bd = bvalid; r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 0;
            if (tw) wvalid <= 0;
            if (bd) bready <= 0;
        end
    endtask : axw
    task automatic axr(input logic [7:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        logic ta, rd;
        rd = 0;
        @(posedge aclk);
        arvalid <= 1; araddr <= a; rready <= 1;
        while (!rd) begin
            @(negedge aclk);
            ta = arvalid && arready; rd = rvalid; d = rdata; r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 0;
            if (rd) rready <= 0;
        end
    endtask : axr
    task automatic regs;
        logic [31:0] d;
        logic [1:0] r;
        axr(8'h30, d, r);
        chk(d, 32'h0);
        axw(8'h30, 32'hff, r);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
        axr(8'h30, d, r);
        chk(d, 32'hf3);
        axr(8'h50, d, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        chk(d, 32'h0);
        axw(8'h50, 32'h0, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        axw(8'h30, 32'h0, r);
        $display("regs done");
    endtask : regs
    task automatic pwm(input logic [1:0] c, input logic [2:0] m,
                       input logic [7:0] va, input logic [7:0] vb,
                       input int per, input int ea, input int eb);
        logic [31:0] ha, hb;
        logic [1:0] r;
        axw(8'h34, 32'h0, r);
        axw(8'h38, {24'h0, va}, r);
        axw(8'h3c, {24'h0, vb}, r);
        axw(8'h30, {24'h0, c, c, 2'b00, m[1:0]}, r);
        axw(8'h40, 32'h0, r);
        axw(8'h34, {28'h0, m[2], 3'b001}, r);
        repeat (600) @(posedge aclk);
        ha = 0;
        hb = 0;
        repeat (per) begin
            @(negedge aclk);
            ha += (lvl_a === 1'b1);
            hb += (lvl_b === 1'b1);
        end
        chk(ha, ea);
        chk(hb, eb);
        $display("pwm code %0d mode %0d done", c, m);
    endtask : pwm
    task automatic port_path;
        logic [1:0] r;
        axw(8'h30, 32'h02, r);
        pa_d <= 1; pb_d <= 0;
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        chk({lvl_a, lvl_b}, 32'h2);
        pa_dir <= 0;
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        chk({pb_oe, pa_oe, lvl_a}, 32'h5);
        pa_dir <= 1;
        $display("port path done");
    endtask : port_path
    task automatic misc;
        logic [31:0] d, e, f, g, ha;
        logic [1:0] r;
        axw(8'h34, 32'h0, r);
        axw(8'h30, 32'h53, r);
        axw(8'h44, 32'h7, r);
        pa_d <= 0;
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        d = {31'h0, lvl_a};
        @(posedge aclk);
        pa_d <= 1;
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        chk({d[0], lvl_a}, 32'h1);
        axw(8'h34, 32'h1, r);
        axr(8'h40, d, r);
        repeat (20) @(posedge aclk);
        axr(8'h40, e, r);
        // same spacing, but the counter must lose exactly the frozen edges
        ce <= 0;
        repeat (20) @(posedge aclk);
        ce <= 1;
        axr(8'h40, f, r);
        g = e - d - (f - e);
        chk({24'h0, g[7:0]}, 32'h14);
        repeat (256) @(posedge aclk);
        axr(8'h44, d, r);
        chk({31'h0, d[0]}, 32'h1);
        axw(8'h34, 32'h9, r);
        axw(8'h30, 32'hc0, r);
        repeat (8) @(posedge aclk);
        ha = 0;
        repeat (256) begin
            @(negedge aclk);
            ha += (lvl_a === 1'b1);
        end
        chk({31'h0, ha == 32'h0 || ha == 32'h100}, 32'h1);
        $display("misc done");
    endtask : misc
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1;
        pa_dir <= 1; pb_dir <= 1;
        regs();
        pwm(2'h1, 3'h2, 8'h03, 8'h03, 8, 4, 4);
        pwm(2'h2, 3'h2, 8'h03, 8'h03, 8, 0, 0);
        pwm(2'h3, 3'h2, 8'h03, 8'h03, 8, 8, 8);
        pwm(2'h2, 3'h3, 8'h80, 8'h80, 256, 129, 129);
        pwm(2'h3, 3'h3, 8'h80, 8'h80, 256, 127, 127);
        pwm(2'h2, 3'h3, 8'hff, 8'hff, 256, 256, 256);
        pwm(2'h2, 3'h7, 8'h07, 8'h03, 8, 8, 4);
        pwm(2'h2, 3'h1, 8'h80, 8'h80, 510, 256, 256);
        pwm(2'h3, 3'h1, 8'h80, 8'h80, 510, 254, 254);
        port_path();
        misc();
        test_done();
    end
    initial begin
        #(50 * 20000);
        fails++;
        test_done();
    end
endmodule : testbench
